// >>> design/tcl_cluster.sv
// Notes on behaviour
// - first two timers: 16-bit, three channels
// - last two timers: 16-bit, two channels
// - overflow and every channel raise interrupts
// - channel zero has no pin
// - channel zero value sets up-count overflow
// - dual timers stay internal, no pin outputs
// - first timer outputs feed second's alternates
// - third timer ch0/ch1 feed fourth's alternates
// - first pair outputs key the transmit pin
// - enable, polarity, keying, source, data bits
// - real-time counter: 16-bit modulo, runs in sleep
// - real-time counter wakes from low-power clock
// - subsystem clock source only while active
// - real-time overflow feeds first timer ch1 alternate
// - trigger select one: overflow starts conversion
// - trigger select: soft, real-time, second ch1
`timescale 1ns/10ps
`default_nettype none
module tcl_cluster
  import tcl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // count sources
  input  wire logic        aux_tick,
  input  wire logic        subsystem_clock_tick,
  input  wire logic [1:0]  external_timer_clock_pin,
  // capture pins of the first pair
  input  wire logic [2:1]  first_triple_cap_pin,
  input  wire logic [2:1]  second_triple_cap_pin,
  // timer configuration
  input  wire logic [1:0]  tmr_clk_sel   [4],
  input  wire logic [1:0]  tmr_mode      [4],
  input  wire logic [2:0]  ch_cap_mode   [4],
  input  wire logic [1:0]  ch_in_sel     [4][3],
  input  wire logic [2:0]  ch_cap_fall   [4],
  input  wire logic [1:0]  ch_out_mode   [4][3],
  input  wire logic [2:0]  ch_out_bit    [4],
  // compare value write
  input  wire logic        ccr_wr_en,
  input  wire logic [1:0]  ccr_wr_tmr,
  input  wire logic [1:0]  ccr_wr_ch,
  input  wire logic [15:0] ccr_wr_data,
  // flag clears
  input  wire logic [3:0]  tmr_ovf_clr,
  input  wire logic [2:0]  tmr_ch_clr    [4],
  // timer status
  output var  logic [15:0] tmr_count     [4],
  output var  logic [15:0] tmr_ccr       [4][3],
  output logic      [3:0]  tmr_ovf_flag,
  output var  logic [2:0]  tmr_ch_flag   [4],
  output logic      [3:0]  tmr_irq,
  // timer pin outputs
  output logic      [2:1]  first_triple_out,
  output logic      [2:1]  second_triple_out,
  // real-time counter
  input  wire logic        rtc_enable,
  input  wire logic [1:0]  rtc_src_sel,
  input  wire logic        active_operation,
  input  wire logic        crystal_oscillator_tick,
  input  wire logic        very_low_freq_oscillator_tick,
  input  wire logic [15:0] rtc_modulo,
  input  wire logic        rtc_flag_clr,
  output logic      [15:0] rtc_count,
  output logic             rtc_flag,
  output logic             rtc_wake,
  // converter trigger
  input  wire logic [1:0]  conversion_trigger_select,
  input  wire logic        conversion_soft_start,
  output logic             conversion_start,
  // infrared modulation
  input  wire logic        serial_tx_data,
  input  wire logic        infrared_enable,
  input  wire logic        infrared_polarity_select,
  input  wire logic        infrared_keying_select,
  input  wire logic        infrared_data_source_select,
  input  wire logic        infrared_soft_data,
  output logic             serial_transmit_pin
);

  // pin synchronisers
  logic [TCL_NSYNC-1:0] sync1_r, sync1_nxt;   // first stage only feeds second
  logic [TCL_NSYNC-1:0] sync2_r, sync2_nxt;   // safe copy of the pins
  logic [1:0]           ext_d_r, ext_d_nxt;   // previous clock pin level
  logic [1:0]           ext_tick;             // clock pin rising edge
  // real-time counter state
  logic [15:0]          rtc_cnt_r, rtc_cnt_nxt;
  logic                 rtc_evt_r, rtc_evt_nxt;
  logic                 rtc_flag_r, rtc_flag_nxt;
  logic                 rtc_tick;
  // converter trigger state
  logic                 adc_r, adc_nxt;
  logic                 tch1_d_r, tch1_d_nxt;
  // infrared state
  logic                 ir_r, ir_nxt;
  logic                 ir_data;
  logic                 ir_mod;
  // cross-connection nets
  logic [2:0]           ch_out_all [4];
  logic [2:0]           prim_all   [4];
  logic [2:0]           alt_all    [4];

  // timer count source choice
  function automatic logic pick_tick(input logic [1:0] sel, input logic pin, input logic aux,
                                     input logic sub);
    case (sel)
      TCL_TCK_PIN:  pick_tick = pin;
      TCL_TCK_AUX:  pick_tick = aux;
      TCL_TCK_SUB:  pick_tick = sub;
      TCL_TCK_NONE: pick_tick = 1'b0;
      default:      pick_tick = 1'b0;
    endcase
  endfunction

  // synchroniser next values
  always_comb
  begin
    sync1_nxt  = {external_timer_clock_pin, second_triple_cap_pin, first_triple_cap_pin};
    sync2_nxt  = sync1_r;
    ext_d_nxt  = sync2_r[5:4];
    ext_tick   = sync2_r[5:4] & ~ext_d_r;
  end

  // synchroniser registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      ext_d_r <= '0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      ext_d_r <= ext_d_nxt;
    end
  end

  // capture input wiring between timers
  always_comb
  begin
    // primary inputs: channel zero has none
    prim_all[0] = {sync2_r[1:0], 1'b0};
    prim_all[1] = {sync2_r[3:2], 1'b0};
    prim_all[2] = 3'h0;
    prim_all[3] = 3'h0;
    // alternate inputs
    alt_all[0]  = {1'b0, rtc_evt_r, 1'b0};
    alt_all[1]  = ch_out_all[0];
    alt_all[2]  = 3'h0;
    alt_all[3]  = {1'b0, ch_out_all[2][1:0]};
  end

  // four timers, two with three channels and two with two
  for (genvar t = 0; t < TCL_NUM_TMR; t++)
  begin : g_tmr
    localparam int NCH = (t < 2) ? 3 : 2;
    tcl_tmr_if #(.NCH(NCH)) tif ();

    // count source: only the first pair owns a clock pin
    assign tif.tick    = pick_tick(tmr_clk_sel[t], (t < 2) ? ext_tick[t % 2] : 1'b0, aux_tick,
                                   subsystem_clock_tick);
    assign tif.mode    = tmr_mode[t];
    assign tif.wr_en   = ccr_wr_en & (ccr_wr_tmr == 2'(t));
    assign tif.wr_ch   = ccr_wr_ch;
    assign tif.wr_data = ccr_wr_data;
    assign tif.ovf_clr = tmr_ovf_clr[t];
    assign tmr_count[t]    = tif.count;
    assign tmr_ovf_flag[t] = tif.ovf_flag;
    // one request line per timer
    assign tmr_irq[t]      = tif.ovf_flag | (|tif.ch_flag);

    for (genvar c = 0; c < TCL_MAX_CH; c++)
    begin : g_ch
      if (c < NCH)
      begin : g_used
        assign tif.cap_mode[c] = ch_cap_mode[t][c];
        assign tif.in_sel[c]   = ch_in_sel[t][c];
        assign tif.cap_fall[c] = ch_cap_fall[t][c];
        assign tif.out_mode[c] = ch_out_mode[t][c];
        assign tif.out_bit[c]  = ch_out_bit[t][c];
        assign tif.ch_clr[c]   = tmr_ch_clr[t][c];
        assign tif.prim_in[c]  = prim_all[t][c];
        assign tif.alt_in[c]   = alt_all[t][c];
        assign ch_out_all[t][c]  = tif.ch_out[c];
        assign tmr_ch_flag[t][c] = tif.ch_flag[c];
        assign tmr_ccr[t][c]     = tif.ccr[c];
      end
      else
      begin : g_absent
        // no third channel on dual timers
        assign ch_out_all[t][c]  = 1'b0;
        assign tmr_ch_flag[t][c] = 1'b0;
        assign tmr_ccr[t][c]     = TCL_CNT_RST;
      end
    end

    tcl_timer #(.NCH(NCH)) u_tmr
    (
      .clk   (clk),
      .reset (reset),
      .tif   (tif)
    );
  end

  // pin outputs of the first pair only
  assign first_triple_out  = ch_out_all[0][2:1];
  assign second_triple_out = ch_out_all[1][2:1];

  // real-time counter next values
  always_comb
  begin
    // low-power sources always, subsystem while active
    case (rtc_src_sel)
      TCL_RTC_XTAL: rtc_tick = crystal_oscillator_tick;
      TCL_RTC_VLO:  rtc_tick = very_low_freq_oscillator_tick;
      TCL_RTC_SUB:  rtc_tick = subsystem_clock_tick & active_operation;
      TCL_RTC_OFF:  rtc_tick = 1'b0;
      default:      rtc_tick = 1'b0;
    endcase
    rtc_cnt_nxt = rtc_cnt_r;
    rtc_evt_nxt = 1'b0;
    if (!rtc_enable)
    begin
      // disabled counter restarts from zero
      rtc_cnt_nxt = TCL_CNT_RST;
    end
    else if (rtc_tick)
    begin
      // modulo wrap, no gating by sleep state
      if (rtc_cnt_r >= rtc_modulo)
      begin
        rtc_cnt_nxt = TCL_CNT_RST;
        rtc_evt_nxt = 1'b1;
      end
      else
      begin
        rtc_cnt_nxt = rtc_cnt_r + TCL_CNT_ONE;
      end
    end
    // sticky flag, event beats clear
    rtc_flag_nxt = rtc_evt_r ? 1'b1 : (rtc_flag_clr ? 1'b0 : rtc_flag_r);
  end

  // real-time counter registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rtc_cnt_r  <= TCL_CNT_RST;
      rtc_evt_r  <= 1'b0;
      rtc_flag_r <= 1'b0;
    end
    else
    begin
      rtc_cnt_r  <= rtc_cnt_nxt;
      rtc_evt_r  <= rtc_evt_nxt;
      rtc_flag_r <= rtc_flag_nxt;
    end
  end

  assign rtc_count = rtc_cnt_r;
  assign rtc_flag  = rtc_flag_r;
  // overflow pulse wakes the processor
  assign rtc_wake  = rtc_evt_r;

  // converter trigger next values
  always_comb
  begin
    tch1_d_nxt = ch_out_all[1][1];
    case (conversion_trigger_select)
      TCL_ADC_SOFT: adc_nxt = conversion_soft_start;
      TCL_ADC_RTC:  adc_nxt = rtc_evt_r;
      TCL_ADC_TMR:  adc_nxt = ch_out_all[1][1] & ~tch1_d_r;
      TCL_ADC_NONE: adc_nxt = 1'b0;
      default:      adc_nxt = 1'b0;
    endcase
  end

  // converter trigger registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adc_r    <= 1'b0;
      tch1_d_r <= 1'b0;
    end
    else
    begin
      adc_r    <= adc_nxt;
      tch1_d_r <= tch1_d_nxt;
    end
  end

  assign conversion_start = adc_r;

  // infrared modulation next value
  always_comb
  begin
    // data from the serial stream or software
    ir_data = (infrared_data_source_select == TCL_IRD_SOFT) ? infrared_soft_data : serial_tx_data;
    // ask gates one carrier, fsk picks one of two
    if (infrared_keying_select == TCL_IR_FSK)
      ir_mod = ir_data ? ch_out_all[0][2] : ch_out_all[1][2];
    else
      ir_mod = ir_data & ch_out_all[0][2];
    // polarity, and plain serial data when disabled
    if (infrared_enable)
      ir_nxt = infrared_polarity_select ? ~ir_mod : ir_mod;
    else
      ir_nxt = serial_tx_data;
  end

  // infrared output register
  always_ff @(posedge clk)
  begin
    if (reset)
      ir_r <= TCL_TX_IDLE;
    else
      ir_r <= ir_nxt;
  end

  assign serial_transmit_pin = ir_r;

endmodule
`default_nettype wire

// >>> design/tcl_pkg.sv
package tcl_pkg;

  // sizes of the cluster
  localparam int          TCL_NUM_TMR  = 4;
  localparam int          TCL_MAX_CH   = 3;
  localparam int          TCL_CW       = 16;
  localparam int          TCL_NSYNC    = 6;

  // reset and limit values
  localparam logic [15:0] TCL_CNT_RST  = 16'h0000;
  localparam logic [15:0] TCL_CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] TCL_CNT_ONE  = 16'h0001;
  localparam logic        TCL_TX_IDLE  = 1'h1;

  // counter operating modes
  typedef enum logic [1:0]
  {
    TCL_MODE_STOP = 2'b00,
    TCL_MODE_UP   = 2'b01,
    TCL_MODE_CONT = 2'b10,
    TCL_MODE_HALT = 2'b11
  } tcl_mode_e;

  // timer count source
  typedef enum logic [1:0]
  {
    TCL_TCK_PIN  = 2'b00,
    TCL_TCK_AUX  = 2'b01,
    TCL_TCK_SUB  = 2'b10,
    TCL_TCK_NONE = 2'b11
  } tcl_tck_e;

  // capture input choice
  typedef enum logic [1:0]
  {
    TCL_CIN_PRIM = 2'b00,
    TCL_CIN_ALT  = 2'b01,
    TCL_CIN_GND  = 2'b10,
    TCL_CIN_VCC  = 2'b11
  } tcl_cin_e;

  // channel output behaviour
  typedef enum logic [1:0]
  {
    TCL_OUT_BIT    = 2'b00,
    TCL_OUT_TOGGLE = 2'b01,
    TCL_OUT_SETCMP = 2'b10,
    TCL_OUT_CLRCMP = 2'b11
  } tcl_out_e;

  // real-time counter source
  typedef enum logic [1:0]
  {
    TCL_RTC_XTAL = 2'b00,
    TCL_RTC_VLO  = 2'b01,
    TCL_RTC_SUB  = 2'b10,
    TCL_RTC_OFF  = 2'b11
  } tcl_rtc_e;

  // converter trigger source
  typedef enum logic [1:0]
  {
    TCL_ADC_SOFT = 2'b00,
    TCL_ADC_RTC  = 2'b01,
    TCL_ADC_TMR  = 2'b10,
    TCL_ADC_NONE = 2'b11
  } tcl_adc_e;

  // infrared keying and data source
  localparam logic        TCL_IR_ASK    = 1'h0;
  localparam logic        TCL_IR_FSK    = 1'h1;
  localparam logic        TCL_IRD_SER   = 1'h0;
  localparam logic        TCL_IRD_SOFT  = 1'h1;

endpackage

// >>> design/tcl_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tcl_tmr_if #(parameter int NCH = 3);
  // configuration from the cluster
  logic             tick;
  logic [1:0]       mode;
  logic [NCH-1:0]   cap_mode;
  logic [1:0]       in_sel   [NCH];
  logic [NCH-1:0]   cap_fall;
  logic [1:0]       out_mode [NCH];
  logic [NCH-1:0]   out_bit;
  // compare value write
  logic             wr_en;
  logic [1:0]       wr_ch;
  logic [15:0]      wr_data;
  // flag clears
  logic             ovf_clr;
  logic [NCH-1:0]   ch_clr;
  // capture inputs
  logic [NCH-1:0]   prim_in;
  logic [NCH-1:0]   alt_in;
  // timer state
  logic [15:0]      count;
  logic [15:0]      ccr      [NCH];
  logic             ovf_flag;
  logic [NCH-1:0]   ch_flag;
  logic [NCH-1:0]   ch_out;

  // cluster side
  modport ctl (output tick, mode, cap_mode, in_sel, cap_fall, out_mode, out_bit,
               output wr_en, wr_ch, wr_data, ovf_clr, ch_clr, prim_in, alt_in,
               input  count, ccr, ovf_flag, ch_flag, ch_out);
  // timer side
  modport tmr (input  tick, mode, cap_mode, in_sel, cap_fall, out_mode, out_bit,
               input  wr_en, wr_ch, wr_data, ovf_clr, ch_clr, prim_in, alt_in,
               output count, ccr, ovf_flag, ch_flag, ch_out);
endinterface
`default_nettype wire

// >>> design/tcl_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tcl_timer
  import tcl_pkg::*;
#(
  parameter int NCH = 3
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // cluster link
  tcl_tmr_if.tmr    tif
);

  // counter and channel state
  logic [15:0]    cnt_r,    cnt_nxt;
  logic [15:0]    ccr_r     [NCH];
  logic [15:0]    ccr_nxt   [NCH];
  logic           ovf_r,    ovf_nxt;
  logic [NCH-1:0] flag_r,   flag_nxt;
  logic [NCH-1:0] out_r,    out_nxt;
  logic [NCH-1:0] cin_d_r,  cin_d_nxt;
  // per cycle events
  logic           wrap;
  logic [NCH-1:0] cin;
  logic [NCH-1:0] cap;
  logic [NCH-1:0] cmp;

  // capture input select
  function automatic logic pick_cin(input logic [1:0] sel, input logic prim, input logic alt);
    case (sel)
      TCL_CIN_PRIM: pick_cin = prim;
      TCL_CIN_ALT:  pick_cin = alt;
      TCL_CIN_GND:  pick_cin = 1'b0;
      TCL_CIN_VCC:  pick_cin = 1'b1;
      default:      pick_cin = 1'b0;
    endcase
  endfunction

  // next timer state
  always_comb
  begin
    cnt_nxt   = cnt_r;
    wrap      = 1'b0;
    case (tif.mode)
      TCL_MODE_UP:
      begin
        // up count wraps after the period value
        if (tif.tick)
        begin
          if (cnt_r >= ccr_r[0])
          begin
            cnt_nxt = TCL_CNT_RST;
            wrap    = 1'b1;
          end
          else
          begin
            cnt_nxt = cnt_r + TCL_CNT_ONE;
          end
        end
      end
      TCL_MODE_CONT:
      begin
        // free run over the full 16-bit range
        if (tif.tick)
        begin
          wrap    = (cnt_r == TCL_CNT_MAX);
          cnt_nxt = cnt_r + TCL_CNT_ONE;
        end
      end
      default:
      begin
        // stopped: hold
        cnt_nxt = cnt_r;
      end
    endcase
    // overflow flag, set beats clear
    ovf_nxt = wrap ? 1'b1 : (tif.ovf_clr ? 1'b0 : ovf_r);
    for (int i = 0; i < NCH; i++)
    begin
      cin[i]       = pick_cin(tif.in_sel[i], tif.prim_in[i], tif.alt_in[i]);
      cin_d_nxt[i] = cin[i];
      // capture on the chosen input edge
      cap[i]       = tif.cap_mode[i] & (tif.cap_fall[i] ? (cin_d_r[i] & ~cin[i]) : (~cin_d_r[i] & cin[i]));
      // compare on a counted step at the value
      cmp[i]       = ~tif.cap_mode[i] & tif.tick & (cnt_r == ccr_r[i]) &
                     ((tif.mode == TCL_MODE_UP) | (tif.mode == TCL_MODE_CONT));
      // captured count beats a software write
      if (cap[i])
        ccr_nxt[i] = cnt_r;
      else if (tif.wr_en && (tif.wr_ch == 2'(i)))
        ccr_nxt[i] = tif.wr_data;
      else
        ccr_nxt[i] = ccr_r[i];
      // channel flag, set beats clear
      flag_nxt[i]  = (cap[i] | cmp[i]) ? 1'b1 : (tif.ch_clr[i] ? 1'b0 : flag_r[i]);
      // channel output shaping
      case (tif.out_mode[i])
        TCL_OUT_BIT:    out_nxt[i] = tif.out_bit[i];
        TCL_OUT_TOGGLE: out_nxt[i] = cmp[i] ? ~out_r[i] : out_r[i];
        TCL_OUT_SETCMP: out_nxt[i] = cmp[i] ? 1'b1 : (wrap ? 1'b0 : out_r[i]);
        TCL_OUT_CLRCMP: out_nxt[i] = cmp[i] ? 1'b0 : (wrap ? 1'b1 : out_r[i]);
        default:        out_nxt[i] = out_r[i];
      endcase
    end
  end

  // register all timer state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r   <= TCL_CNT_RST;
      ovf_r   <= 1'b0;
      flag_r  <= '0;
      out_r   <= '0;
      cin_d_r <= '0;
      for (int i = 0; i < NCH; i++)
        ccr_r[i] <= TCL_CNT_RST;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      ovf_r   <= ovf_nxt;
      flag_r  <= flag_nxt;
      out_r   <= out_nxt;
      cin_d_r <= cin_d_nxt;
      for (int i = 0; i < NCH; i++)
        ccr_r[i] <= ccr_nxt[i];
    end
  end

  // state to the cluster
  assign tif.count    = cnt_r;
  assign tif.ovf_flag = ovf_r;
  assign tif.ch_flag  = flag_r;
  assign tif.ch_out   = out_r;
  for (genvar g = 0; g < NCH; g++)
  begin : g_ccr
    assign tif.ccr[g] = ccr_r[g];
  end

endmodule
`default_nettype wire

// >>> verification/tcl_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcl_src_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // pace of the sources
  input  wire logic       slow,
  // count sources and serial data
  output logic            aux_tick,
  output logic            subsystem_clock_tick,
  output logic            crystal_oscillator_tick,
  output logic            very_low_freq_oscillator_tick,
  output logic [1:0]      external_timer_clock_pin,
  output logic            serial_tx_data
);
  logic [3:0] div_r; // free running divider

  // divider behind every source except the subsystem tick
  always_ff @(posedge clk)
    div_r <= reset ? 4'h0 : div_r + 4'h1;

  // tick every cycle, or one in four when slow
  assign aux_tick = !reset && (!slow || div_r[1:0] == 2'h0);
  assign crystal_oscillator_tick = aux_tick;
  assign very_low_freq_oscillator_tick = !reset && div_r[0];
  assign subsystem_clock_tick = !reset;
  // pin high and low two cycles each
  assign external_timer_clock_pin = {2{div_r[1]}};
  assign serial_tx_data = ~div_r[3];
endmodule
`default_nettype wire

// >>> verification/tcl_cluster_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tcl_cluster_monitor
  import tcl_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // timer status
  input wire logic [1:0]  tmr_mode [4],
  input wire logic [15:0] tmr_count [4],
  input wire logic [15:0] tmr_ccr [4][3],
  input wire logic [3:0]  tmr_ovf_flag,
  input wire logic [2:0]  tmr_ch_flag [4],
  input wire logic [3:0]  tmr_irq,
  input wire logic [2:1]  first_triple_out,
  input wire logic [2:1]  second_triple_out,
  // real-time counter and converter trigger
  input wire logic        rtc_flag,
  input wire logic        rtc_wake,
  input wire logic [1:0]  conversion_trigger_select,
  input wire logic        conversion_soft_start,
  input wire logic        conversion_start,
  // infrared path
  input wire logic        serial_tx_data,
  input wire logic        infrared_enable,
  input wire logic        infrared_polarity_select,
  input wire logic        infrared_keying_select,
  input wire logic        infrared_data_source_select,
  input wire logic        infrared_soft_data,
  input wire logic        serial_transmit_pin
);
  logic [3:0] irq_exp; // or of each timer's flags

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // expected interrupt lines
  always_comb
    for (int i = 0; i < 4; i++)
      irq_exp[i] = tmr_ovf_flag[i] | (|tmr_ch_flag[i]);

  irq_or_a: assert property (tmr_irq == irq_exp)
    else $error("irq not or of flags");
  dual_ch2_a: assert property (!tmr_ccr[2][2] && !tmr_ccr[3][2] && !tmr_ch_flag[2][2])
    else $error("dual third channel");
  up_wrap_a: assert property (tmr_mode[0] == 2'h1 && tmr_count[0] == tmr_ccr[0][0] && |tmr_count[0]
    |=> (!tmr_count[0] && tmr_ovf_flag[0]) || $stable(tmr_count[0])) else $error("up count missed wrap");
  conv_soft_a: assert property (conversion_trigger_select == 2'h0 && conversion_soft_start |=> conversion_start)
    else $error("no soft conversion");
  conv_rtc_a: assert property (conversion_trigger_select == 2'h1 && rtc_wake |=> conversion_start)
    else $error("no event conversion");
  rtc_flag_a: assert property (rtc_wake |=> rtc_flag)
    else $error("counter flag not set");
  ir_pass_a: assert property (!infrared_enable |=> serial_transmit_pin == $past(serial_tx_data))
    else $error("serial pass wrong");
  ir_ask_a: assert property (infrared_enable && !infrared_keying_select && infrared_data_source_select
    |=> serial_transmit_pin == ($past(infrared_polarity_select) ^ ($past(infrared_soft_data) & $past(first_triple_out[2]))))
    else $error("ask output wrong");
  ir_fsk_a: assert property (infrared_enable && infrared_keying_select && infrared_data_source_select
    |=> serial_transmit_pin == ($past(infrared_polarity_select) ^ ($past(infrared_soft_data) ? $past(first_triple_out[2])
    : $past(second_triple_out[2])))) else $error("fsk output wrong");

  // main scenarios reached
  wrap_c: cover property (tmr_ovf_flag[0]);
  wake_c: cover property (rtc_wake);
  conv_c: cover property (conversion_start);
endmodule

bind tcl_cluster tcl_cluster_monitor u_tcl_cluster_monitor (.*);
`default_nettype wire

// >>> verification/tcl_cluster_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcl_cluster_tb;
  import tcl_pkg::*;
  // clock, reset and sources
  logic clk = 1'b0, reset = 1'b1, slow = 1'b0;
  logic aux_tick, subsystem_clock_tick, crystal_oscillator_tick, very_low_freq_oscillator_tick, serial_tx_data;
  logic [1:0] external_timer_clock_pin;
  // timer controls
  logic [2:1] first_triple_cap_pin = 2'h0, second_triple_cap_pin = 2'h0;
  logic [1:0] tmr_clk_sel [4] = '{4{2'h1}}, tmr_mode [4] = '{4{2'h0}};
  logic [2:0] ch_cap_mode [4] = '{4{3'h0}}, ch_cap_fall [4] = '{4{3'h0}};
  logic [2:0] ch_out_bit [4] = '{4{3'h0}}, tmr_ch_clr [4] = '{4{3'h0}};
  logic [1:0] ch_in_sel [4][3] = '{default: 2'h2}, ch_out_mode [4][3] = '{default: 2'h0};
  logic ccr_wr_en = 1'b0;
  logic [1:0] ccr_wr_tmr = 2'h0, ccr_wr_ch = 2'h0;
  logic [15:0] ccr_wr_data = 16'h0000, rtc_modulo = 16'h0004;
  logic [3:0] tmr_ovf_clr = 4'h0;
  // counter, trigger, infrared
  logic rtc_enable = 1'b0, active_operation = 1'b1, rtc_flag_clr = 1'b0, conversion_soft_start = 1'b0;
  logic [1:0] rtc_src_sel = 2'h0, conversion_trigger_select = 2'h3;
  logic infrared_enable = 1'b0, infrared_polarity_select = 1'b0, infrared_keying_select = 1'b0;
  logic infrared_data_source_select = 1'b0, infrared_soft_data = 1'b0;
  // design outputs
  logic [15:0] tmr_count [4], tmr_ccr [4][3], rtc_count;
  logic [2:0] tmr_ch_flag [4];
  logic [3:0] tmr_ovf_flag, tmr_irq;
  logic [2:1] first_triple_out, second_triple_out;
  logic rtc_flag, rtc_wake, conversion_start, serial_transmit_pin;
  // bench state
  int num_errors = 0, checks = 0, cyc = 0, conv_cnt = 0, wake_cnt = 0;
  logic ser_q, d, m;
  logic [15:0] c, e;

  tcl_src_model u_tcl_src_model (.*);
  tcl_cluster u_tcl_cluster (.*);

  always #2 clk = ~clk;

  // pulse counters and hang limit
  always @(posedge clk)
  begin
    ser_q <= serial_tx_data;
    conv_cnt <= conv_cnt + conversion_start;
    wake_cnt <= wake_cnt + rtc_wake;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle write of a channel value
  task automatic wr_ccr(input int t, input int ch, input logic [15:0] v);
    ccr_wr_tmr = 2'(t);
    ccr_wr_ch = 2'(ch);
    ccr_wr_data = v;
    ccr_wr_en = 1'b1;
    step(1);
    ccr_wr_en = 1'b0;
    step(1);
  endtask

  // clear every flag of one timer
  task automatic clr(input int t);
    tmr_ch_clr[t] = 3'h7;
    tmr_ovf_clr[t] = 1'b1;
    step(1);
    tmr_ch_clr[t] = 3'h0;
    tmr_ovf_clr[t] = 1'b0;
  endtask

  task automatic finish_test();
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    step(5);
    reset = 1'b0;
    step(1);
    check("idle pin", serial_transmit_pin, 1'b1);
    // up count, compare, stop per timer
    for (int t = 0; t < 4; t++)
    begin
      wr_ccr(t, 0, 16'(2 + t));
      wr_ccr(t, 1, 16'h0001);
      check("period value", tmr_ccr[t][0], 16'(2 + t));
      tmr_mode[t] = 2'h1;
      for (int k = 0; k < 12; k++)
      begin
        c = tmr_count[t];
        step(1);
        check("up count", tmr_count[t], (c >= 16'(2 + t)) ? 16'h0000 : c + 16'h0001);
      end
      check("overflow flag", tmr_ovf_flag[t], 1'b1);
      check("compare flag", tmr_ch_flag[t][1], 1'b1);
      tmr_mode[t] = 2'(3 * (t % 2));
      step(1);
      c = tmr_count[t];
      clr(t);
      step(2);
      check("stopped count", tmr_count[t], c);
      check("flags cleared", tmr_irq[t], 1'b0);
    end
    // capture sources, first timer channel one
    tmr_mode[0] = 2'h2;
    ch_cap_mode[0] = 3'h2;
    ch_in_sel[0][1] = 2'h3;
    step(4);
    check("supply capture", tmr_ch_flag[0][1], 1'b1);
    ch_in_sel[0][1] = 2'h0;
    step(4);
    clr(0);
    first_triple_cap_pin[1] = 1'b1;
    step(5);
    check("pin capture", tmr_ch_flag[0][1], 1'b1);
    ch_in_sel[0][1] = 2'h1;
    step(4);
    clr(0);
    rtc_enable = 1'b1;
    step(10);
    check("event capture", tmr_ch_flag[0][1], 1'b1);
    for (int k = 0; k < 10; k++)
    begin
      c = rtc_count;
      step(1);
      check("modulo count", rtc_count, (c >= rtc_modulo) ? 16'h0000 : c + 16'h0001);
    end
    rtc_src_sel = 2'h2;
    active_operation = 1'b0;
    step(2);
    c = rtc_count;
    step(4);
    check("sleep gate", rtc_count, c);
    active_operation = 1'b1;
    step(2);
    check("active source", rtc_count != c, 16'h0001);
    rtc_src_sel = 2'h1;
    slow = 1'b1;
    rtc_flag_clr = 1'b1;
    step(1);
    rtc_flag_clr = 1'b0;
    step(24);
    check("slow clock wake", rtc_flag, 1'b1);
    rtc_enable = 1'b0;
    slow = 1'b0;
    // converter trigger choices
    for (int s = 0; s < 4; s++)
    begin
      conversion_trigger_select = 2'(s);
      step(3);
      e = 16'(conv_cnt);
      conversion_soft_start = 1'b1;
      step(1);
      conversion_soft_start = 1'b0;
      step(3);
      check("soft start", 16'(conv_cnt) - e, s == 0);
    end
    conversion_trigger_select = 2'h1;
    e = 16'(wake_cnt);
    c = 16'(conv_cnt - wake_cnt);
    rtc_src_sel = 2'h0;
    rtc_enable = 1'b1;
    step(30);
    rtc_enable = 1'b0;
    step(3);
    check("counter events", wake_cnt > e, 16'h0001);
    check("event trigger", 16'(conv_cnt - wake_cnt), c);
    conversion_trigger_select = 2'h2;
    e = 16'(conv_cnt);
    ch_out_bit[1][1] = 1'b1;
    step(4);
    check("timer trigger", 16'(conv_cnt) - e, 16'h0001);
    conversion_trigger_select = 2'h3;
    ch_cap_mode[0] = 3'h0;
    // chained alternate captures
    for (int p = 0; p < 4; p += 2)
      for (int ch = 0; ch < 3 - p / 2; ch++)
      begin
        ch_cap_mode[p + 1] = 3'h7;
        ch_in_sel[p + 1][ch] = 2'h1;
        ch_out_bit[p] = 3'h0;
        step(4);
        clr(p + 1);
        ch_out_bit[p][ch] = 1'b1;
        step(5);
        check("chained capture", tmr_ch_flag[p + 1][ch], 1'b1);
      end
    ch_cap_mode = '{4{3'h0}};
    // all infrared settings, both carriers
    for (int i = 0; i < 128; i++)
    begin
      {ch_out_bit[1][2], ch_out_bit[0][2], infrared_soft_data, infrared_data_source_select,
       infrared_keying_select, infrared_polarity_select, infrared_enable} = 7'(i);
      step(3);
      d = infrared_data_source_select ? infrared_soft_data : ser_q;
      m = infrared_keying_select ? (d ? ch_out_bit[0][2] : ch_out_bit[1][2]) : (d & ch_out_bit[0][2]);
      check("transmit pin", serial_transmit_pin, infrared_enable ? infrared_polarity_select ^ m : ser_q);
    end
    finish_test();
  end
endmodule
`default_nettype wire
